// file: pmu_link_pkg.sv
// Shared constants, types and state codes for the PMU two-wire link
// Assumes a 100 MHz core clock on both ends
package pmu_link_pkg;
	// Register pointers of the target bank
	localparam logic [7:0] REG_GENERAL  = 8'h00;
	localparam logic [7:0] REG_CONV1_HI = 8'h08;
	localparam logic [7:0] REG_CONV1_LO = 8'h09;
	localparam logic [7:0] REG_CONV2_HI = 8'h0a;
	localparam logic [7:0] REG_CONV2_LO = 8'h0b;
	localparam int         BANK_DEPTH   = 16;
	// Field positions
	localparam int GEN_CONV1_LEVEL_SELECT_BIT = 2;
	localparam int GEN_CONV2_LEVEL_SELECT_BIT = 3;
	localparam int CODE_MSB                   = 4;
	// Reset values
	localparam logic [7:0] RST_GENERAL  = 8'h00;
	localparam logic [7:0] RST_CONV1_HI = 8'h14;
	localparam logic [7:0] RST_CONV1_LO = 8'h0c;
	localparam logic [7:0] RST_CONV2_HI = 8'h14;
	localparam logic [7:0] RST_CONV2_LO = 8'h0c;
	localparam logic [7:0] RST_OTHER    = 8'h00;
	// Target address, value is arbitrary
	localparam logic [6:0] TARGET_ADDR = 7'h2a;
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SCL_PERIOD_NS   = 160;
	localparam int BUS_FREE_NS     = 1300;
	localparam int STARTUP_STEP_NS = 1000;
	localparam int QUARTER_CYC     = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int BUS_FREE_CYC    = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC     = (STARTUP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host command registers
	localparam logic [7:0] HOST_TARGET  = 8'h00;
	localparam logic [7:0] HOST_POINTER = 8'h01;
	localparam logic [7:0] HOST_WDATA   = 8'h02;
	localparam logic [7:0] HOST_CTRL    = 8'h03;
	localparam logic [7:0] HOST_STATUS  = 8'h04;
	localparam logic [7:0] HOST_RDATA   = 8'h05;
	localparam int CTRL_GO_WRITE   = 0;
	localparam int CTRL_GO_READ    = 1;
	localparam int STATUS_BUSY     = 0;
	localparam int STATUS_NACK     = 1;
	// Host bus operations
	localparam logic [1:0] OP_START = 2'h0;
	localparam logic [1:0] OP_TX    = 2'h1;
	localparam logic [1:0] OP_RX    = 2'h2;
	localparam logic [1:0] OP_STOP  = 2'h3;
	typedef logic [BANK_DEPTH-1:0][7:0] bank_t;
	typedef enum logic [4:0] {
		D_IDLE = 5'b00001, D_RECV = 5'b00010, D_ACK = 5'b00100, D_XMIT = 5'b01000, D_MACK = 5'b10000
	} dev_state_e;
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001, H_START = 5'b00010, H_BIT = 5'b00100, H_STOP = 5'b01000, H_FREE = 5'b10000
	} host_state_e;
	localparam logic [1:0] PH_ADDR = 2'h0;
	localparam logic [1:0] PH_PTR  = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;
endpackage

// file: pmu_link_if.sv
// Two-wire link between host controller and PMU target
// Lines are open drain with pull-ups; the interface resolves the wired level
`timescale 1ns/1ps
interface pmu_link_if;
	logic scl_out;
	logic scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// Wired-AND with pull-up
	assign scl = scl_oe_n | scl_out;
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
	modport host (output scl_out, output scl_oe_n, output host_sda_out, output host_sda_oe_n, input scl, input sda);
	modport target (output dev_sda_out, output dev_sda_oe_n, input scl, input sda);
endinterface

// file: line_sync.sv
// Two-flop synchroniser for pin inputs
// Assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module line_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// Stage shift
	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	// Idle-high reset matches pulled-up lines
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule

// file: pmu_target.sv
// PMU serial target with register bank and converter voltage selection
// Assumes the link lines arrive asynchronous to clk; samples them at 100 MHz
`timescale 1ns/1ps
// How it works
// - Converter 2 code chosen by general bit 3
// - Converter 1 code chosen by select pin only
// - Each converter holds two programmable codes
// - All voltage registers writable over serial link
// - Power-on enables converters in order, default codes
// - One bit per clock, sample high, change low
// - Data change during clock high aborts transaction
// - Bytes are eight bits, MSB first
// - Acknowledge slot follows every byte
// - Transaction is start, bytes, stop
// - Only the host makes start and stop
// - Start is data falling while clock high
// - Stop is data rising while clock high
// - Bus busy from start until stop plus free
// - Repeated start restarts address reception
// - Seven address bits, then direction, match acks
// - Write: pointer byte, data, pointer increments
// - Read returns pointed byte, increments on ack
// - Ninth pulse: transmitter releases, receiver pulls low
module pmu_target (
	input  wire logic       clk,
	input  wire logic       rst,
	pmu_link_if.target      link,
	input  wire logic       conv1_level_pin,
	output logic      [4:0] conv1_code,
	output logic      [4:0] conv2_code,
	output logic      [1:0] conv_enable,
	output logic            bus_busy
);
	logic [2:0]              pins_s;
	logic                    scl_s;
	logic                    sda_s;
	logic                    pin_s;
	logic                    scl_d;
	logic                    sda_d;
	pmu_link_pkg::dev_state_e state;
	pmu_link_pkg::dev_state_e next_state;
	pmu_link_pkg::bank_t     bank;
	pmu_link_pkg::bank_t     next_bank;
	logic [3:0]              bitcnt;
	logic [3:0]              next_bitcnt;
	logic [7:0]              shift;
	logic [7:0]              next_shift;
	logic [7:0]              ptr;
	logic [7:0]              next_ptr;
	logic [1:0]              phase;
	logic [1:0]              next_phase;
	logic                    rw;
	logic                    next_rw;
	logic                    acked;
	logic                    next_acked;
	logic                    pull;
	logic                    next_pull;
	logic                    freeing;
	logic                    next_freeing;
	logic                    next_busy;
	logic [10:0]             free_cnt;
	logic [10:0]             next_free_cnt;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_cond;
	logic                    stop_cond;
	logic [4:0]              next_conv1_code;
	logic [4:0]              next_conv2_code;
	logic [7:0]              seq_cnt;
	logic [7:0]              next_seq_cnt;
	logic [1:0]              next_conv_enable;

	// Byte at a pointer, zero beyond the bank
	function automatic logic [7:0] read_byte(input pmu_link_pkg::bank_t b, input logic [7:0] p);
		read_byte = (p < 8'(pmu_link_pkg::BANK_DEPTH)) ? b[p[3:0]] : 8'h00;
	endfunction

	// Reset contents of the bank
	function automatic pmu_link_pkg::bank_t bank_reset();
		bank_reset = {pmu_link_pkg::BANK_DEPTH{pmu_link_pkg::RST_OTHER}};
		bank_reset[pmu_link_pkg::REG_GENERAL[3:0]]  = pmu_link_pkg::RST_GENERAL;
		bank_reset[pmu_link_pkg::REG_CONV1_HI[3:0]] = pmu_link_pkg::RST_CONV1_HI;
		bank_reset[pmu_link_pkg::REG_CONV1_LO[3:0]] = pmu_link_pkg::RST_CONV1_LO;
		bank_reset[pmu_link_pkg::REG_CONV2_HI[3:0]] = pmu_link_pkg::RST_CONV2_HI;
		bank_reset[pmu_link_pkg::REG_CONV2_LO[3:0]] = pmu_link_pkg::RST_CONV2_LO;
	endfunction

	// Pin synchroniser
	line_sync #(.W(3)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({link.scl, link.sda, conv1_level_pin}),
		.q   (pins_s)
	);

	// Line events from synchronised samples
	assign scl_s      = pins_s[2];
	assign sda_s      = pins_s[1];
	assign pin_s      = pins_s[0];
	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

	// Open drain: value always low, enable carries the data
	assign link.dev_sda_out = 1'b0;

	// Link protocol and register bank
	always_comb begin
		next_state    = state;
		next_bank     = bank;
		next_bitcnt   = bitcnt;
		next_shift    = shift;
		next_ptr      = ptr;
		next_phase    = phase;
		next_rw       = rw;
		next_acked    = acked;
		next_pull     = pull;
		next_freeing  = freeing;
		next_busy     = bus_busy;
		next_free_cnt = free_cnt;
		if (start_cond) begin
			next_state    = pmu_link_pkg::D_RECV;
			next_bitcnt   = 4'h0;
			next_phase    = pmu_link_pkg::PH_ADDR;
			next_pull     = 1'b0;
			next_busy     = 1'b1;
			next_freeing  = 1'b0;
		end else if (stop_cond) begin
			next_state    = pmu_link_pkg::D_IDLE;
			next_pull     = 1'b0;
			next_freeing  = 1'b1;
			next_free_cnt = 11'h000;
		end else begin
			unique case (state)
				pmu_link_pkg::D_IDLE: begin
				end
				pmu_link_pkg::D_RECV: begin
					if (scl_rise) begin
						next_shift  = {shift[6:0], sda_s};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						next_state = pmu_link_pkg::D_ACK;
						next_pull  = 1'b1;
						unique case (phase)
							pmu_link_pkg::PH_ADDR: begin
								next_rw = shift[0];
								if (shift[7:1] != pmu_link_pkg::TARGET_ADDR) begin
									next_state = pmu_link_pkg::D_IDLE;
									next_pull  = 1'b0;
								end
							end
							pmu_link_pkg::PH_PTR: next_ptr = shift;
							default: begin
								if (ptr < 8'(pmu_link_pkg::BANK_DEPTH)) begin
									next_bank[ptr[3:0]] = shift;
								end
							end
						endcase
					end
				end
				pmu_link_pkg::D_ACK: begin
					if (scl_fall) begin
						next_bitcnt = 4'h0;
						if (phase == pmu_link_pkg::PH_ADDR && rw) begin
							next_state = pmu_link_pkg::D_XMIT;
							next_shift = read_byte(bank, ptr);
							next_pull  = ~next_shift[7];
						end else begin
							next_state = pmu_link_pkg::D_RECV;
							next_pull  = 1'b0;
							if (phase == pmu_link_pkg::PH_DATA) begin
								next_ptr = ptr + 8'h01;
							end
							next_phase = (phase == pmu_link_pkg::PH_ADDR) ? pmu_link_pkg::PH_PTR : pmu_link_pkg::PH_DATA;
						end
					end
				end
				pmu_link_pkg::D_XMIT: begin
					if (scl_fall) begin
						if (bitcnt == 4'h7) begin
							next_state = pmu_link_pkg::D_MACK;
							next_pull  = 1'b0;
						end else begin
							next_shift  = {shift[6:0], 1'b0};
							next_pull   = ~shift[6];
							next_bitcnt = bitcnt + 4'h1;
						end
					end
				end
				pmu_link_pkg::D_MACK: begin
					if (scl_rise) begin
						next_acked = ~sda_s;
					end else if (scl_fall) begin
						if (acked) begin
							next_state  = pmu_link_pkg::D_XMIT;
							next_ptr    = ptr + 8'h01;
							next_shift  = read_byte(bank, ptr + 8'h01);
							next_pull   = ~next_shift[7];
							next_bitcnt = 4'h0;
						end else begin
							next_state = pmu_link_pkg::D_IDLE;
						end
					end
				end
			endcase
		end
		// Bus free interval after stop
		// A start seen in the last free cycle keeps the bus busy
		if (freeing && !stop_cond && !start_cond) begin
			if (free_cnt == 11'(pmu_link_pkg::BUS_FREE_CYC - 1)) begin
				next_freeing = 1'b0;
				next_busy    = 1'b0;
			end else begin
				next_free_cnt = free_cnt + 11'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= pmu_link_pkg::D_IDLE;
			bank     <= bank_reset();
			bitcnt   <= 4'h0;
			shift    <= 8'h00;
			ptr      <= 8'h00;
			phase    <= pmu_link_pkg::PH_ADDR;
			rw       <= 1'b0;
			acked    <= 1'b0;
			pull     <= 1'b0;
			freeing  <= 1'b0;
			bus_busy <= 1'b0;
			free_cnt <= 11'h000;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			state    <= next_state;
			bank     <= next_bank;
			bitcnt   <= next_bitcnt;
			shift    <= next_shift;
			ptr      <= next_ptr;
			phase    <= next_phase;
			rw       <= next_rw;
			acked    <= next_acked;
			pull     <= next_pull;
			freeing  <= next_freeing;
			bus_busy <= next_busy;
			free_cnt <= next_free_cnt;
			scl_d    <= scl_s;
			sda_d    <= sda_s;
		end
	end

	// Data enable is low while pulling the line low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link.dev_sda_oe_n <= 1'b1;
		end else begin
			link.dev_sda_oe_n <= ~next_pull;
		end
	end

	// Voltage code selection; general bit 2 has no effect on converter 1
	always_comb begin
		next_conv1_code = pin_s ? bank[pmu_link_pkg::REG_CONV1_HI[3:0]][pmu_link_pkg::CODE_MSB:0]
		                        : bank[pmu_link_pkg::REG_CONV1_LO[3:0]][pmu_link_pkg::CODE_MSB:0];
		next_conv2_code = bank[pmu_link_pkg::REG_GENERAL[3:0]][pmu_link_pkg::GEN_CONV2_LEVEL_SELECT_BIT]
		                ? bank[pmu_link_pkg::REG_CONV2_HI[3:0]][pmu_link_pkg::CODE_MSB:0]
		                : bank[pmu_link_pkg::REG_CONV2_LO[3:0]][pmu_link_pkg::CODE_MSB:0];
	end

	// Startup order: converter 1, then converter 2
	always_comb begin
		next_seq_cnt     = seq_cnt;
		next_conv_enable = conv_enable;
		if (conv_enable != 2'b11) begin
			if (seq_cnt == 8'(pmu_link_pkg::STARTUP_CYC - 1)) begin
				next_seq_cnt     = 8'h00;
				next_conv_enable = {conv_enable[0], 1'b1};
			end else begin
				next_seq_cnt = seq_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv1_code  <= 5'h00;
			conv2_code  <= 5'h00;
			seq_cnt     <= 8'h00;
			conv_enable <= 2'b00;
		end else begin
			conv1_code  <= next_conv1_code;
			conv2_code  <= next_conv2_code;
			seq_cnt     <= next_seq_cnt;
			conv_enable <= next_conv_enable;
		end
	end
endmodule

// file: pmu_host.sv
// Host controller: single-byte register write and read on the PMU link
// Assumes software on a plain strobe port; drives the clock line itself
`timescale 1ns/1ps
module pmu_host (
	input  wire logic       clk,
	input  wire logic       rst,
	pmu_link_if.host        link,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata
);
	pmu_link_pkg::host_state_e state;
	pmu_link_pkg::host_state_e next_state;
	logic       sda_s;
	logic [6:0] target;
	logic [6:0] next_target;
	logic [7:0] pointer;
	logic [7:0] next_pointer;
	logic [7:0] wbyte;
	logic [7:0] next_wbyte;
	logic [7:0] rbyte;
	logic [7:0] next_rbyte;
	logic       nack;
	logic       next_nack;
	logic       is_read;
	logic       next_is_read;
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic [1:0] q;
	logic [1:0] next_q;
	logic [3:0] bitn;
	logic [3:0] next_bitn;
	logic [10:0] cnt;
	logic [10:0] next_cnt;
	logic       scl_low;
	logic       next_scl_low;
	logic       sda_low;
	logic       next_sda_low;
	logic [7:0] next_rdata;
	logic       tick;
	logic [1:0] op;
	logic [7:0] txb;

	// Operation of each stage
	function automatic logic [1:0] stage_op(input logic [2:0] s, input logic r);
		unique case (s)
			3'h0: stage_op = pmu_link_pkg::OP_START;
			3'h1, 3'h2: stage_op = pmu_link_pkg::OP_TX;
			3'h3: stage_op = r ? pmu_link_pkg::OP_START : pmu_link_pkg::OP_TX;
			3'h4: stage_op = r ? pmu_link_pkg::OP_TX : pmu_link_pkg::OP_STOP;
			3'h5: stage_op = pmu_link_pkg::OP_RX;
			default: stage_op = pmu_link_pkg::OP_STOP;
		endcase
	endfunction

	line_sync #(.W(1)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (link.sda),
		.q   (sda_s)
	);

	assign tick = (cnt == 11'(pmu_link_pkg::QUARTER_CYC - 1));
	assign op   = stage_op(stage, is_read);
	assign txb  = (stage == 3'h1) ? {target, 1'b0} : (stage == 3'h2) ? pointer
	            : (stage == 3'h4) ? {target, 1'b1} : wbyte;
	assign link.scl_out      = 1'b0;
	assign link.host_sda_out = 1'b0;

	// Command registers and bit engine
	always_comb begin
		next_state   = state;
		next_target  = target;
		next_pointer = pointer;
		next_wbyte   = wbyte;
		next_rbyte   = rbyte;
		next_nack    = nack;
		next_is_read = is_read;
		next_stage   = stage;
		next_q       = q;
		next_bitn    = bitn;
		next_cnt     = (state == pmu_link_pkg::H_IDLE || tick) ? 11'h000 : cnt + 11'h001;
		next_scl_low = scl_low;
		next_sda_low = sda_low;
		unique case (addr)
			pmu_link_pkg::HOST_STATUS: next_rdata = {6'h00, nack, state != pmu_link_pkg::H_IDLE};
			pmu_link_pkg::HOST_RDATA:  next_rdata = rbyte;
			pmu_link_pkg::HOST_TARGET: next_rdata = {1'b0, target};
			pmu_link_pkg::HOST_POINTER: next_rdata = pointer;
			default: next_rdata = 8'h00;
		endcase
		if (!rd) begin
			next_rdata = 8'h00;
		end
		if (wr && addr == pmu_link_pkg::HOST_TARGET)  next_target  = wdata[6:0];
		if (wr && addr == pmu_link_pkg::HOST_POINTER) next_pointer = wdata;
		if (wr && addr == pmu_link_pkg::HOST_WDATA)   next_wbyte   = wdata;
		unique case (state)
			pmu_link_pkg::H_IDLE: begin
				if (wr && addr == pmu_link_pkg::HOST_CTRL && (wdata[pmu_link_pkg::CTRL_GO_WRITE] || wdata[pmu_link_pkg::CTRL_GO_READ])) begin
					next_state   = pmu_link_pkg::H_START;
					next_is_read = wdata[pmu_link_pkg::CTRL_GO_READ];
					next_nack    = 1'b0;
					next_stage   = 3'h0;
					next_q       = 2'h0;
				end
			end
			pmu_link_pkg::H_START: begin
				if (tick) begin
					next_q = q + 2'h1;
					unique case (q)
						2'h0: next_sda_low = 1'b0;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b1;
						default: begin
							next_scl_low = 1'b1;
							next_stage   = stage + 3'h1;
							next_bitn    = 4'h0;
							next_state   = pmu_link_pkg::H_BIT;
						end
					endcase
				end
			end
			pmu_link_pkg::H_BIT: begin
				if (tick) begin
					next_q = q + 2'h1;
					unique case (q)
						2'h0: next_sda_low = (op == pmu_link_pkg::OP_TX && bitn < 4'h8) ? ~txb[3'(4'h7 - bitn)] : 1'b0;
						2'h1: next_scl_low = 1'b0;
						2'h2: begin
							if (op == pmu_link_pkg::OP_TX && bitn == 4'h8) next_nack = sda_s;
							if (op == pmu_link_pkg::OP_RX && bitn < 4'h8) next_rbyte = {rbyte[6:0], sda_s};
						end
						default: begin
							next_scl_low = 1'b1;
							next_bitn    = bitn + 4'h1;
							if (bitn == 4'h8) begin
								next_bitn  = 4'h0;
								next_stage = stage + 3'h1;
								if (nack || stage_op(stage + 3'h1, is_read) == pmu_link_pkg::OP_STOP) begin
									next_state = pmu_link_pkg::H_STOP;
								end else if (stage_op(stage + 3'h1, is_read) == pmu_link_pkg::OP_START) begin
									next_state = pmu_link_pkg::H_START;
								end
							end
						end
					endcase
				end
			end
			pmu_link_pkg::H_STOP: begin
				if (tick) begin
					next_q = q + 2'h1;
					unique case (q)
						2'h0: next_sda_low = 1'b1;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b0;
						default: next_state = pmu_link_pkg::H_FREE;
					endcase
				end
			end
			pmu_link_pkg::H_FREE: begin
				next_cnt = cnt + 11'h001;
				if (cnt == 11'(pmu_link_pkg::BUS_FREE_CYC - 1)) begin
					next_state = pmu_link_pkg::H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state              <= pmu_link_pkg::H_IDLE;
			target             <= pmu_link_pkg::TARGET_ADDR;
			pointer            <= 8'h00;
			wbyte              <= 8'h00;
			rbyte              <= 8'h00;
			nack               <= 1'b0;
			is_read            <= 1'b0;
			stage              <= 3'h0;
			q                  <= 2'h0;
			bitn               <= 4'h0;
			cnt                <= 11'h000;
			scl_low            <= 1'b0;
			sda_low            <= 1'b0;
			rdata              <= 8'h00;
			link.scl_oe_n      <= 1'b1;
			link.host_sda_oe_n <= 1'b1;
		end else begin
			state              <= next_state;
			target             <= next_target;
			pointer            <= next_pointer;
			wbyte              <= next_wbyte;
			rbyte              <= next_rbyte;
			nack               <= next_nack;
			is_read            <= next_is_read;
			stage              <= next_stage;
			q                  <= next_q;
			bitn               <= next_bitn;
			cnt                <= next_cnt;
			scl_low            <= next_scl_low;
			sda_low            <= next_sda_low;
			rdata              <= next_rdata;
			link.scl_oe_n      <= ~next_scl_low;
			link.host_sda_oe_n <= ~next_sda_low;
		end
	end
endmodule

// file: pmu_link_chk.sv
// Link checker: watches the resolved lines and the data enables of both ends
// Assumes the bench wires it beside the link interface
`timescale 1ns/1ps
module pmu_link_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n
);
	logic       scl_q;
	logic       sda_q;
	logic       in_xfer;
	logic       next_in_xfer;
	logic [7:0] free_cnt;
	logic [7:0] next_free_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_start; scl && $past(scl) && $fell(sda); endsequence
	sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
	// Frame flag and saturating count of cycles since the last stop
	always_comb begin
		next_in_xfer = (scl && scl_q && sda_q && !sda) ? 1'b1 : ((scl && scl_q && !sda_q && sda) ? 1'b0 : in_xfer);
		next_free_cnt = (scl && scl_q && !sda_q && sda) ? 8'h00 : ((free_cnt == 8'hff) ? free_cnt : free_cnt + 8'h01);
	end
	// Register helper state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_xfer <= 1'b0;
			free_cnt <= 8'hff;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			in_xfer <= next_in_xfer;
			free_cnt <= next_free_cnt;
		end
	end
	a_dev_low_only: assert property ((dev_sda_out == 1'b0) && (dev_sda_oe_n || !sda)) else $error("target data not low");
	a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl) else $error("target moved data in clock high");
	a_start_by_host: assert property (s_start |-> $fell(host_sda_oe_n)) else $error("start not made by host");
	a_stop_by_host: assert property (s_stop |-> $rose(host_sda_oe_n)) else $error("stop not made by host");
	a_ack_held: assert property (!dev_sda_oe_n && $rose(scl) |=> !dev_sda_oe_n [*6]) else $error("low not held");
	a_clk_high_min: assert property ($rose(scl) |=> scl [*6]) else $error("clock pulse too short");
	a_free_gap: assert property (s_start |-> free_cnt >= pmu_link_pkg::BUS_FREE_CYC - 1) else $error("bus free too short");
	a_dev_in_frame: assert property (!dev_sda_oe_n |-> in_xfer) else $error("target drives outside a frame");
endmodule

// file: pmu_serial_regs_voltage_select_tb.sv
// Bench: host controller and PMU target joined by one link
// Assumes 100 MHz clock; the host makes the link clock itself
`timescale 1ns/1ps
module pmu_serial_regs_voltage_select_tb;
	localparam logic [7:0] tgt = {1'b0, pmu_link_pkg::TARGET_ADDR};
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       pin = 1'b0;
	logic [7:0] rdata;
	logic [4:0] conv1_code;
	logic [4:0] conv2_code;
	logic [1:0] conv_enable;
	logic       bus_busy;
	logic [7:0] got;
	logic [31:0] r;
	int         n_fail = 0;
	int         total_checks = 0;
	int         seed = 23433;
	int         bank [16];
	logic [7:0] regs [6] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h00, 8'h0f};
	pmu_link_if link ();
	pmu_host pmu_host_i (.clk(clk), .rst(rst), .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	pmu_target pmu_target_i (.clk(clk), .rst(rst), .link(link), .conv1_level_pin(pin), .conv1_code(conv1_code),
		.conv2_code(conv2_code), .conv_enable(conv_enable), .bus_busy(bus_busy));
	pmu_link_chk pmu_link_chk_i (.clk(clk), .rst(rst), .scl(link.scl), .sda(link.sda),
		.host_sda_oe_n(link.host_sda_oe_n), .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n));
	always #5 clk = ~clk;
	// Compare and count
	task automatic check(string what, logic [7:0] exp, logic [7:0] seen);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One write strobe, then an idle edge
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read strobe; data taken in the following cycle only
	task automatic rd_reg(logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
		@(posedge clk);
	endtask
	// One link transfer, then bounded poll until idle
	task automatic op(logic [7:0] t, logic [7:0] p, logic [7:0] d, logic [1:0] go);
		int i;
		wr_reg(pmu_link_pkg::HOST_TARGET, t);
		wr_reg(pmu_link_pkg::HOST_POINTER, p);
		wr_reg(pmu_link_pkg::HOST_WDATA, d);
		wr_reg(pmu_link_pkg::HOST_CTRL, {6'h00, go});
		repeat (40) @(posedge clk);
		check("bus_busy", 8'h01, {7'h00, bus_busy});
		for (i = 0; i < 1000; i++) begin
			rd_reg(pmu_link_pkg::HOST_STATUS);
			if (got[0] === 1'b0)
				break;
		end
		if (i == 1000) begin
			check("poll_limit", 8'h00, 8'h01);
			end_of_test();
		end
		check("bus_free", 8'h00, {7'h00, bus_busy});
	endtask
	// Selected codes against the model
	task automatic codes();
		repeat (6) @(posedge clk);
		check("conv1_code", {3'h0, pin ? bank[8][4:0] : bank[9][4:0]}, {3'h0, conv1_code});
		check("conv2_code", {3'h0, bank[0][3] ? bank[10][4:0] : bank[11][4:0]}, {3'h0, conv2_code});
	endtask
	// Main sequence
	initial begin
		bank = '{8: pmu_link_pkg::RST_CONV1_HI, 9: pmu_link_pkg::RST_CONV1_LO,
			10: pmu_link_pkg::RST_CONV2_HI, 11: pmu_link_pkg::RST_CONV2_LO, default: 0};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (150) @(posedge clk);
		check("conv_enable", 8'h01, {6'h00, conv_enable});
		repeat (100) @(posedge clk);
		check("conv_enable", 8'h03, {6'h00, conv_enable});
		codes();
		foreach (regs[k]) begin
			r = $random(seed);
			pin <= r[8];
			op(tgt, regs[k], r[7:0], 2'h1);
			bank[regs[k]] = r[7:0];
			op(tgt, regs[k], 8'h00, 2'h2);
			rd_reg(pmu_link_pkg::HOST_RDATA);
			check("read_back", r[7:0], got);
			codes();
		end
		op(tgt + 8'h01, 8'h08, 8'h1f, 2'h1);
		rd_reg(pmu_link_pkg::HOST_STATUS);
		check("nack", 8'h02, got & 8'h02);
		op(tgt, 8'h08, 8'h00, 2'h2);
		rd_reg(pmu_link_pkg::HOST_RDATA);
		check("untouched", bank[8][7:0], got);
		end_of_test();
	end
endmodule
